//--- bench/spi_host.sv
// host side of the serial link: single, dual or quad lane frames in mode 0, 48 ns clock
// assumes every lane is fed back from the device wire while the device drives it
`timescale 1ns/100ps
`default_nettype none
module spi_host (
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] lane_o,
  input wire logic [3:0] lanes_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    lane_o = 4'h5;
  end
  task automatic sel(input logic on);
    #24 cs_n_o = !on;
    #24;
  endtask : sel
  // idle lanes toggle so a stale level never reads as device data
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int w);
    logic [7:0] s;
    s = tx;
    for (int i = 0; i < 8 / w; i++) begin
      if (w == 1) lane_o = {~lane_o[3:1], s[7]};
      else if (w == 2) lane_o = {~lane_o[3:2], s[7:6]};
      else lane_o = s[7:4];
      s = s << w;
      #24 sck_o = 1'b1;
      if (w == 1) rx = {rx[6:0], lanes_i[1]};
      else if (w == 2) rx = {rx[5:0], lanes_i[1:0]};
      else rx = {rx[3:0], lanes_i};
      #24 sck_o = 1'b0;
    end
  endtask : xfer
endmodule : spi_host
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the flash command front end
// assumes spi_host drives the link; a queue stands in for the array
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [7:0] MK = 8'hc6; // arbitrary value
  localparam logic [15:0] JD = 16'h9e17; // arbitrary value
  localparam logic [7:0] DV = 8'h4b; // arbitrary value
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic busy = 1'b0;
  logic wclr = 1'b0;
  logic wp_n = 1'b1;
  logic rdy = 1'b1;
  logic dval = 1'b0;
  logic [7:0] dat = 8'h00;
  logic sck, cs_n, drdy, rqv;
  logic [3:0] hl, lo, oe, lw;
  logic [23:0] ra;
  logic [15:0] st;
  logic [7:0] got [0:7];
  logic [23:0] pend [$];
  int num_errors = 0;
  int samples_checked = 0;
  int nreq = 0;
  int n0;
  int wid = 1;
  logic [7:0] fill = 8'h00;
  logic [2:0] wb;
  assign lw = (oe & lo) | (~oe & hl);
  initial forever #2.5 clk_i = !clk_i;
  spi_host h (.sck_o(sck), .cs_n_o(cs_n), .lane_o(hl), .lanes_i(lw));
  serial_flash_cmd_front_end #(.STATUS_WRITE_TIME_NS(100), .MAKER_ID(MK),
    .JEDEC_DEV_ID(JD), .DEV_ID(DV)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck),
    .cs_n_i(cs_n), .lane_i(lw), .lane_o(lo), .lane_oe_o(oe), .wp_n_i(wp_n),
    .array_busy_i(busy), .wel_clear_i(wclr), .array_req_valid_o(rqv),
    .array_req_ready_i(rdy), .array_req_addr_o(ra), .array_data_valid_i(dval),
    .array_data_ready_o(drdy), .array_data_i(dat), .status_o(st), .wrap_bits_o(wb));
  // array stand-in: byte is low address bits xor a5
  always @(posedge clk_i) begin
    dval <= 1'b0;
    if (rqv && rdy) begin
      pend.push_back(ra);
      nreq++;
    end
    if (pend.size() > 0 && drdy) begin
      dval <= 1'b1;
      dat <= 8'(pend.pop_front()) ^ 8'ha5;
    end
  end
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask : done
  // settle on a falling edge so outputs of the last rising edge have landed
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wt
  task automatic frame(input logic [31:0] tx, input int ntx, input int nrx);
    logic [7:0] r;
    h.sel(1'b1);
    for (int i = 0; i < ntx + nrx; i++) begin
      h.xfer(i < ntx && i < 4 ? tx[31-8*i -: 8] : fill, r, i == 0 ? 1 : wid);
      if (i >= ntx) got[i-ntx] = r;
    end
    h.sel(1'b0);
    wt(2);
  endtask : frame
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    wt(4);
    check("status at reset", st, 16'h0000);
    frame({8'h06, 24'h0}, 1, 0);
    frame({8'h05, 24'h0}, 1, 2);
    check("status low", {got[0], got[1]}, 16'h0202);
    frame({8'h35, 24'h0}, 1, 1);
    check("status high", {8'h00, got[0]}, 16'h0000);
    @(posedge clk_i) wclr <= 1'b1;
    @(posedge clk_i) wclr <= 1'b0;
    wt(2);
    check("latch after completion", st, 16'h0000);
    frame({8'h06, 24'h0}, 1, 0);
    frame({8'h04, 24'h0}, 1, 0);
    check("latch after clear", st, 16'h0000);
    done("latch");
    frame({8'h50, 24'h0}, 1, 0);
    frame({8'h01, 8'h80, 16'h0}, 2, 0);
    check("volatile write", st, 16'h0080);
    @(posedge clk_i) wp_n <= 1'b0;
    frame({8'h06, 24'h0}, 1, 0);
    frame({8'h01, 8'h00, 16'h0}, 2, 0);
    check("protected write", st & 16'hfffd, 16'h0080);
    @(posedge clk_i) wp_n <= 1'b1;
    frame({8'h06, 24'h0}, 1, 0);
    frame({8'h01, 24'h7c0400}, 4, 0);
    check("long write", st & 16'hfffd, 16'h0080);
    frame({8'h06, 24'h0}, 1, 0);
    frame({8'h01, 8'h7c, 8'h04, 8'h00}, 3, 0);
    check("write cycle busy", 16'(st[1:0]), 16'h0003);
    for (int i = 0; i < 100 && st[0] !== 1'b0; i++) @(posedge clk_i);
    if (st[0] !== 1'b0) begin
      num_errors++;
      stop_test();
    end
    wt(1);
    check("after write cycle", st, 16'h007c);
    done("status write");
    frame({8'h03, 24'hffffff}, 4, 2);
    check("read wrap", {got[0], got[1]}, 16'h5aa5);
    @(posedge clk_i) busy <= 1'b1;
    n0 = nreq;
    frame({8'h03, 24'h000010}, 4, 1);
    check("read while busy", 16'(nreq - n0), 16'h0000);
    done("read");
    h.sel(1'b1);
    h.xfer(8'h25, got[0], 1);
    wt(10);
    check("busy report", 16'({oe[1], lo[1]}), 16'h0003);
    @(posedge clk_i) busy <= 1'b0;
    wt(4);
    check("ready report", 16'({oe[1], lo[1]}), 16'h0002);
    h.sel(1'b0);
    wt(2);
    check("report release", 16'(oe), 16'h0000);
    done("busy report");
    frame({8'h9f, 24'h0}, 1, 4);
    check("id first", {got[0], got[1]}, {MK, JD[15:8]});
    check("id repeat", {got[2], got[3]}, {JD[7:0], MK});
    frame({8'h90, 24'h0}, 4, 2);
    check("maker device", {got[0], got[1]}, {MK, DV});
    frame({8'hab, 24'h0}, 4, 1);
    check("signature", {8'h00, got[0]}, {8'h00, DV});
    done("id");
    wid = 2;
    frame({8'h92, 24'h0}, 5, 2);
    check("dual id", {got[0], got[1]}, {MK, DV});
    wid = 4;
    frame({8'h94, 24'h0}, 7, 2);
    check("quad id", {got[0], got[1]}, {MK, DV});
    frame({8'heb, 24'h000102}, 7, 2);
    check("quad read", {got[0], got[1]}, 16'ha7a6);
    fill = 8'h50;
    frame({8'h77, 24'h0}, 5, 0);
    check("wrap bits", 16'(wb), 16'h0005);
    done("multi lane");
    stop_test();
  end
endmodule : testbench
`default_nettype wire

//--- rtl/byte_fifo.sv
// synchronous fifo with flush, valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign count_o = cnt_q;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        mem_q[i] <= '0;
      end else if (push && wr_q == AW'(i)) begin
        mem_q[i] <= in_data_i;
      end
    end
  end

  no_overfill_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !in_ready_o |-> cnt_q == (AW+1)'(DEPTH))
    else $error("fifo refuses data while not full");
endmodule : byte_fifo
`default_nettype wire

//--- rtl/flash_map.svh
// constants for the serial flash command front end: opcodes, counts, status layout
// assumes one 200 MHz core clock that oversamples the link clock
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH
`define OP_SET_WEL 8'h06
`define OP_CLR_WEL 8'h04
`define OP_VOL_EN 8'h50
`define OP_STAT_LO 8'h05
`define OP_STAT_HI 8'h35
`define OP_BUSY_RPT 8'h25
`define OP_STAT_WR 8'h01
`define OP_READ 8'h03
`define OP_QIO_READ 8'heb
`define OP_WRAP 8'h77
`define OP_ID_JEDEC 8'h9f
`define OP_ID_MD 8'h90
`define OP_ID_MD2 8'h92
`define OP_ID_MD4 8'h94
`define OP_ID_SIG 8'hab
`define LW1 3'h1
`define LW2 3'h2
`define LW4 3'h4
`define OPC_LAST 5'h07
`define ADDR_CLK_X1 5'h18
`define ADDR_CLK_X2 5'h0c
`define ADDR_CLK_X4 5'h06
`define MODE_CLK_X2 5'h04
`define MODE_CLK_X4 5'h02
`define DUMMY_QIO 5'h04
`define WRAP_CLKS 5'h08
`define WRAP_SLOT 5'h06
`define SW_BITS_SHORT 5'h08
`define SW_BITS_LONG 5'h10
`define CNT_SAT 5'h1f
`define BYTE_BITS 4'h8
`define JEDEC_LAST 2'h2
`define WIP_BIT 0
`define WEL_BIT 1
`define PROT_LOW_BIT 7
`define PROT_HIGH_BIT 8
`define S10_BIT 10
`define S15_BIT 15
`define STAT_KEEP_MASK 16'h8403
`define STAT_RESET 16'h0000
`define FIFO_DEPTH 16
`define FIFO_DEPTH_W 6'h10
`define CLK_MHZ 200
`define LAST_ADDR 24'hffffff
`endif

//--- rtl/flash_pkg.sv
// types shared by the flash front end
// assumes flash_map.svh supplies the numeric constants
package flash_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA_OUT, ST_DATA_IN, ST_BUSY_RPT, ST_IGNORE
  } state_e;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_ARRAY, SRC_STAT_LO, SRC_STAT_HI, SRC_ID_JEDEC, SRC_ID_MD, SRC_ID_SIG
  } src_e;
  typedef struct packed {
    logic [2:0] width;
    logic [4:0] addr_clks;
    logic [4:0] mode_clks;
    logic [4:0] dummy_clks;
    src_e src;
    state_e first;
  } cmd_s;
endpackage : flash_pkg

//--- rtl/serial_flash_cmd_front_end.sv
// command front end of a serial nor flash: link decode, latch, status, plain and quad reads
// assumes the array returns bytes in request order, and array_busy_i is on clk_i
`include "flash_map.svh"
`timescale 1ns/100ps
`default_nettype none
module serial_flash_cmd_front_end #(
  parameter int unsigned STATUS_WRITE_TIME_NS = 2000000,
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [15:0] JEDEC_DEV_ID = 16'h7e21, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'h3c // arbitrary value
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] lane_i,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe_o,
  input wire logic wp_n_i,
  input wire logic array_busy_i,
  input wire logic wel_clear_i,
  output logic array_req_valid_o,
  input wire logic array_req_ready_i,
  output logic [23:0] array_req_addr_o,
  input wire logic array_data_valid_i,
  output logic array_data_ready_o,
  input wire logic [7:0] array_data_i,
  output logic [15:0] status_o,
  output logic [2:0] wrap_bits_o
);
  localparam int unsigned SW_RAW = (STATUS_WRITE_TIME_NS * `CLK_MHZ) / 1000;
  localparam logic [31:0] SW_CYCLES = (SW_RAW < 1) ? 32'h1 : 32'(SW_RAW);

  // pins: sck, cs_n, wp_n, lanes
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic [1:0] edge_q;
  logic sck_s;
  logic cs_n_s;
  logic wp_n_s;
  logic [3:0] lane_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  flash_pkg::state_e state_q;
  flash_pkg::cmd_s cmd_q;
  flash_pkg::cmd_s cmd_dec;
  logic [7:0] op_q;
  logic [4:0] cnt_q;
  logic [23:0] in_sr_q;
  logic [23:0] in_next;
  logic [2:0] width_now;
  logic phase_end;

  logic [3:0] lane_q;
  logic [3:0] oe_q;
  logic [7:0] out_sr_q;
  logic [3:0] left_q;
  logic [1:0] idx_q;
  logic [7:0] next_byte;
  logic pop;

  logic wel_q;
  logic [15:0] stat_q;
  logic [15:0] pend_q;
  logic sw_busy_q;
  logic [31:0] timer_q;
  logic vol_arm_q;
  logic vol_use_q;
  logic write_in_progress;
  logic hw_prot;
  logic wel_set;
  logic wel_clr;
  logic sw_done;
  logic sw_frame;
  logic sw_ok;
  logic [15:0] sw_new;
  logic [15:0] sw_merged;
  logic [2:0] wrap_q;

  logic fetch_on_q;
  logic [23:0] fetch_addr_q;
  logic [4:0] outstanding_q;
  logic [4:0] outstanding_next;
  logic [4:0] discard_q;
  logic [4:0] fifo_count;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic issue;
  logic resp;

  function automatic flash_pkg::cmd_s decode(input logic [7:0] op);
    flash_pkg::cmd_s c;
    c.width = `LW1;
    c.addr_clks = '0;
    c.mode_clks = '0;
    c.dummy_clks = '0;
    c.src = flash_pkg::SRC_NONE;
    c.first = flash_pkg::ST_IGNORE;
    case (op)
      `OP_STAT_LO: begin
        c.src = flash_pkg::SRC_STAT_LO;
        c.first = flash_pkg::ST_DATA_OUT;
      end
      `OP_STAT_HI: begin
        c.src = flash_pkg::SRC_STAT_HI;
        c.first = flash_pkg::ST_DATA_OUT;
      end
      `OP_BUSY_RPT: c.first = flash_pkg::ST_BUSY_RPT;
      `OP_STAT_WR: c.first = flash_pkg::ST_DATA_IN;
      `OP_READ: begin
        c.addr_clks = `ADDR_CLK_X1;
        c.src = flash_pkg::SRC_ARRAY;
        c.first = flash_pkg::ST_ADDR;
      end
      `OP_QIO_READ, `OP_ID_MD4: begin
        c.width = `LW4;
        c.addr_clks = `ADDR_CLK_X4;
        c.mode_clks = `MODE_CLK_X4;
        c.dummy_clks = `DUMMY_QIO;
        c.src = (op == `OP_ID_MD4) ? flash_pkg::SRC_ID_MD : flash_pkg::SRC_ARRAY;
        c.first = flash_pkg::ST_ADDR;
      end
      `OP_ID_MD2: begin
        c.width = `LW2;
        c.addr_clks = `ADDR_CLK_X2;
        c.mode_clks = `MODE_CLK_X2;
        c.src = flash_pkg::SRC_ID_MD;
        c.first = flash_pkg::ST_ADDR;
      end
      `OP_ID_MD, `OP_ID_SIG: begin
        c.addr_clks = `ADDR_CLK_X1;
        c.src = (op == `OP_ID_MD) ? flash_pkg::SRC_ID_MD : flash_pkg::SRC_ID_SIG;
        c.first = flash_pkg::ST_ADDR;
      end
      `OP_ID_JEDEC: begin
        c.src = flash_pkg::SRC_ID_JEDEC;
        c.first = flash_pkg::ST_DATA_OUT;
      end
      `OP_WRAP: begin
        c.width = `LW4;
        c.dummy_clks = `WRAP_CLKS;
        c.first = flash_pkg::ST_DUMMY;
      end
      default: c.first = flash_pkg::ST_IGNORE;
    endcase
    return c;
  endfunction : decode

  function automatic logic [4:0] phase_len(input flash_pkg::state_e s, input flash_pkg::cmd_s c);
    if (s == flash_pkg::ST_ADDR) begin
      return c.addr_clks;
    end else if (s == flash_pkg::ST_MODE) begin
      return c.mode_clks;
    end
    return c.dummy_clks;
  endfunction : phase_len

  function automatic flash_pkg::state_e phase_after(input flash_pkg::state_e s,
                                                   input flash_pkg::cmd_s c);
    if (s == flash_pkg::ST_ADDR && c.mode_clks != '0) begin
      return flash_pkg::ST_MODE;
    end
    if (s != flash_pkg::ST_DUMMY && c.dummy_clks != '0) begin
      return flash_pkg::ST_DUMMY;
    end
    return (c.src == flash_pkg::SRC_NONE) ? flash_pkg::ST_IGNORE : flash_pkg::ST_DATA_OUT;
  endfunction : phase_after

  // top bits of a byte onto the lanes for one link clock
  function automatic logic [3:0] lanes_of(input logic [7:0] b, input logic [2:0] w);
    if (w == `LW1) begin
      return {2'h0, b[7], 1'b0};
    end else if (w == `LW2) begin
      return {2'h0, b[7:6]};
    end
    return b[7:4];
  endfunction : lanes_of

  function automatic logic [3:0] oe_of(input logic [2:0] w);
    if (w == `LW1) begin
      return 4'h2;
    end else if (w == `LW2) begin
      return 4'h3;
    end
    return 4'hf;
  endfunction : oe_of

  // sck and cs_n are asynchronous to clk_i; edges are taken after two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 7'h03;
      pin_s2_q <= 7'h03;
      edge_q <= 2'h3;
    end else begin
      pin_s1_q <= {lane_i, wp_n_i, cs_n_i, sck_i};
      pin_s2_q <= pin_s1_q;
      edge_q <= pin_s2_q[1:0];
    end
  end

  assign sck_s = pin_s2_q[0];
  assign cs_n_s = pin_s2_q[1];
  assign wp_n_s = pin_s2_q[2];
  assign lane_s = pin_s2_q[6:3];
  assign sck_rise = sck_s && !edge_q[0];
  assign sck_fall = !sck_s && edge_q[0];
  assign cs_rise = cs_n_s && !edge_q[1];

  assign width_now = (state_q == flash_pkg::ST_OPCODE) ? `LW1 : cmd_q.width;
  always_comb begin
    if (width_now == `LW1) begin
      in_next = {in_sr_q[22:0], lane_s[0]};
    end else if (width_now == `LW2) begin
      in_next = {in_sr_q[21:0], lane_s[1:0]};
    end else begin
      in_next = {in_sr_q[19:0], lane_s};
    end
  end
  assign cmd_dec = decode(in_next[7:0]);
  assign phase_end = (cnt_q == phase_len(state_q, cmd_q) - 5'h1);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= flash_pkg::ST_OPCODE;
      cmd_q <= '{`LW1, 5'h00, 5'h00, 5'h00, flash_pkg::SRC_NONE, flash_pkg::ST_IGNORE};
      op_q <= 8'h00;
      cnt_q <= '0;
      in_sr_q <= '0;
    end else if (cs_n_s) begin
      state_q <= flash_pkg::ST_OPCODE;
      cnt_q <= '0;
    end else if (sck_rise) begin
      in_sr_q <= in_next;
      unique case (state_q)
        flash_pkg::ST_OPCODE: begin
          if (cnt_q == `OPC_LAST) begin
            op_q <= in_next[7:0];
            cmd_q <= cmd_dec;
            cnt_q <= '0;
            if (cmd_dec.src == flash_pkg::SRC_ARRAY && write_in_progress) begin
              state_q <= flash_pkg::ST_IGNORE;
            end else begin
              state_q <= cmd_dec.first;
            end
          end else begin
            cnt_q <= cnt_q + 5'h1;
          end
        end
        flash_pkg::ST_ADDR, flash_pkg::ST_MODE, flash_pkg::ST_DUMMY: begin
          if (phase_end) begin
            cnt_q <= '0;
            state_q <= phase_after(state_q, cmd_q);
          end else begin
            cnt_q <= cnt_q + 5'h1;
          end
        end
        flash_pkg::ST_DATA_IN, flash_pkg::ST_IGNORE: begin
          if (cnt_q != `CNT_SAT) begin
            cnt_q <= cnt_q + 5'h1;
          end
        end
        flash_pkg::ST_DATA_OUT, flash_pkg::ST_BUSY_RPT: cnt_q <= cnt_q;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wrap_q <= '0;
    end else if (sck_rise && state_q == flash_pkg::ST_DUMMY && op_q == `OP_WRAP
                 && cnt_q == `WRAP_SLOT) begin
      wrap_q <= lane_s[2:0];
    end
  end
  assign wrap_bits_o = wrap_q;

  always_comb begin
    unique case (cmd_q.src)
      flash_pkg::SRC_STAT_LO: next_byte = status_o[7:0];
      flash_pkg::SRC_STAT_HI: next_byte = status_o[15:8];
      flash_pkg::SRC_ID_JEDEC: next_byte = (idx_q == 2'h0) ? MAKER_ID :
                                 (idx_q == 2'h1) ? JEDEC_DEV_ID[15:8] : JEDEC_DEV_ID[7:0];
      flash_pkg::SRC_ID_MD: next_byte = idx_q[0] ? DEV_ID : MAKER_ID;
      flash_pkg::SRC_ID_SIG: next_byte = DEV_ID;
      flash_pkg::SRC_ARRAY: next_byte = fifo_data;
      flash_pkg::SRC_NONE: next_byte = 8'h00;
      default: next_byte = 8'h00;
    endcase
  end
  assign pop = state_q == flash_pkg::ST_DATA_OUT && sck_fall && left_q == '0
               && cmd_q.src == flash_pkg::SRC_ARRAY && !cs_n_s;

  // data out lanes change on link falling edges so the host samples on rising ones; the busy report lane updates on every clk_i
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lane_q <= '0;
      oe_q <= '0;
      out_sr_q <= '0;
      left_q <= '0;
      idx_q <= '0;
    end else if (cs_n_s) begin
      oe_q <= '0;
      left_q <= '0;
      idx_q <= '0;
    end else if (state_q == flash_pkg::ST_BUSY_RPT) begin
      lane_q <= {2'h0, write_in_progress, 1'b0};
      oe_q <= 4'h2;
    end else if (state_q == flash_pkg::ST_DATA_OUT && sck_fall) begin
      if (left_q == '0) begin
        lane_q <= lanes_of(next_byte, cmd_q.width);
        out_sr_q <= next_byte << cmd_q.width;
        left_q <= `BYTE_BITS - {1'b0, cmd_q.width};
        idx_q <= (cmd_q.src == flash_pkg::SRC_ID_JEDEC && idx_q == `JEDEC_LAST) ? 2'h0 :
                 idx_q + 2'h1;
        oe_q <= oe_of(cmd_q.width);
      end else begin
        lane_q <= lanes_of(out_sr_q, cmd_q.width);
        out_sr_q <= out_sr_q << cmd_q.width;
        left_q <= left_q - {1'b0, cmd_q.width};
      end
    end
  end
  assign lane_o = lane_q;
  assign lane_oe_o = oe_q;

  assign write_in_progress = sw_busy_q || array_busy_i;
  assign hw_prot = stat_q[`PROT_HIGH_BIT] || (stat_q[`PROT_LOW_BIT] && !wp_n_s);
  assign status_o = {stat_q[15:2], wel_q, write_in_progress};
  assign wel_set = cs_rise && state_q == flash_pkg::ST_IGNORE && cnt_q == '0
                   && op_q == `OP_SET_WEL;
  assign wel_clr = cs_rise && state_q == flash_pkg::ST_IGNORE && cnt_q == '0
                   && op_q == `OP_CLR_WEL;
  assign sw_done = sw_busy_q && timer_q == '0;
  assign sw_frame = cs_rise && state_q == flash_pkg::ST_DATA_IN
                    && (cnt_q == `SW_BITS_SHORT || cnt_q == `SW_BITS_LONG);
  assign sw_ok = sw_frame && !write_in_progress && !hw_prot && (vol_use_q || wel_q);
  assign sw_new = (cnt_q == `SW_BITS_LONG) ? {in_sr_q[7:0], in_sr_q[15:8]} :
                  {stat_q[15:8], in_sr_q[7:0]};
  assign sw_merged = (sw_new & ~`STAT_KEEP_MASK) | (stat_q & `STAT_KEEP_MASK);

  // a set in the same cycle as a completion wins
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wel_q <= 1'b0;
    end else if (wel_set) begin
      wel_q <= 1'b1;
    end else if (wel_clr || sw_done || wel_clear_i) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vol_arm_q <= 1'b0;
      vol_use_q <= 1'b0;
    end else if (cs_rise && state_q == flash_pkg::ST_IGNORE && cnt_q == '0
                 && op_q == `OP_VOL_EN) begin
      vol_arm_q <= 1'b1;
    end else if (sck_rise && !cs_n_s && state_q == flash_pkg::ST_OPCODE
                 && cnt_q == `OPC_LAST) begin
      vol_use_q <= vol_arm_q && in_next[7:0] == `OP_STAT_WR;
      vol_arm_q <= 1'b0;
    end
  end

  // volatile writes take effect at once; the retained copy waits out the timed cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_q <= `STAT_RESET;
      pend_q <= `STAT_RESET;
      sw_busy_q <= 1'b0;
      timer_q <= '0;
    end else if (sw_ok && vol_use_q) begin
      stat_q <= sw_merged;
    end else if (sw_ok) begin
      pend_q <= sw_merged;
      sw_busy_q <= 1'b1;
      timer_q <= SW_CYCLES - 32'h1;
    end else if (sw_done) begin
      stat_q <= pend_q;
      sw_busy_q <= 1'b0;
    end else if (sw_busy_q) begin
      timer_q <= timer_q - 32'h1;
    end
  end

  // prefetch from the array; replies still in flight at frame end are dropped
  assign issue = array_req_valid_o && array_req_ready_i;
  assign resp = array_data_valid_i && array_data_ready_o;
  assign array_req_valid_o = fetch_on_q && !cs_n_s
                             && ({1'b0, outstanding_q} + {1'b0, fifo_count}) < `FIFO_DEPTH_W;
  assign array_req_addr_o = fetch_addr_q;
  assign array_data_ready_o = (discard_q != '0) || fifo_in_ready;
  assign outstanding_next = outstanding_q + 5'(issue) - 5'(resp);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fetch_on_q <= 1'b0;
      fetch_addr_q <= '0;
      outstanding_q <= '0;
      discard_q <= '0;
    end else begin
      outstanding_q <= outstanding_next;
      if (cs_n_s) begin
        fetch_on_q <= 1'b0;
        discard_q <= outstanding_next;
      end else begin
        if (resp && discard_q != '0) begin
          discard_q <= discard_q - 5'h1;
        end
        if (sck_rise && state_q == flash_pkg::ST_ADDR && phase_end
            && cmd_q.src == flash_pkg::SRC_ARRAY) begin
          fetch_on_q <= 1'b1;
          fetch_addr_q <= in_next;
        end else if (issue) begin
          fetch_addr_q <= fetch_addr_q + 24'h1;
        end
      end
    end
  end

  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .flush_i(cs_n_s),
    .in_valid_i(array_data_valid_i && discard_q == '0),
    .in_ready_o(fifo_in_ready),
    .in_data_i(array_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data),
    .count_o(fifo_count)
  );

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  wel_set_a: assert property (wel_set |=> wel_q)
    else $error("latch not set by set command");
  wel_clear_a: assert property (wel_clr |=> !wel_q)
    else $error("latch not cleared by clear command");
  wel_auto_a: assert property ((sw_done || wel_clear_i) && !wel_set |=> !wel_q)
    else $error("latch survives a completion");
  sw_start_a: assert property (sw_ok && !vol_use_q |=> status_o[`WIP_BIT] && sw_busy_q)
    else $error("status write cycle did not start");
  sw_end_a: assert property ($fell(sw_busy_q) && !$past(wel_set) |-> !wel_q)
    else $error("latch still set after status write");
  keep_bits_a: assert property ($stable(stat_q[`S15_BIT]) && $stable(stat_q[`S10_BIT]))
    else $error("protected status bit changed");
  prot_block_a: assert property (sw_frame && hw_prot && !sw_busy_q
                                 |=> !sw_busy_q && $stable(stat_q))
    else $error("status write under hardware protection");
  busy_rpt_a: assert property (state_q == flash_pkg::ST_BUSY_RPT && !cs_n_s
                               |=> lane_oe_o[1] && lane_o[1] == $past(write_in_progress))
    else $error("busy report does not follow write in progress");
  release_a: assert property (cs_rise |=> lane_oe_o == 4'h0 [*2])
    else $error("output not released at deselect");
  read_reject_a: assert property (state_q == flash_pkg::ST_IGNORE |-> !array_req_valid_o)
    else $error("array fetched for a rejected command");
  wrap_addr_a: assert property (issue && array_req_addr_o == `LAST_ADDR && !cs_n_s
                                |=> array_req_addr_o == 24'h0)
    else $error("read address did not wrap to zero");
endmodule : serial_flash_cmd_front_end
`default_nettype wire
